// *** core/asc_defs.svh ***
// register offsets, field positions and reset values of the stop-flow block
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
`define ASC_OFF_CTRL  8'h00
`define ASC_OFF_FLOW  8'h04
`define ASC_OFF_STAT  8'h08
`define ASC_OFF_BASE  8'h0C
`define ASC_OFF_OFFS  8'h10
`define ASC_OFF_RIDX  8'h14
`define ASC_OFF_ISTAT 8'h18
`define ASC_OFF_ICLR  8'h1C
`define ASC_OFF_IEN   8'h20
`define ASC_OFF_RES   8'h24
`define ASC_CTRL_EN    0
`define ASC_CTRL_STORE 1
`define ASC_CTRL_FMODE 2
`define ASC_CTRL_AUTO  3
`define ASC_CTRL_JUST  4
`define ASC_CTRL_RESLO 5
`define ASC_CTRL_RESHI 6
`define ASC_CTRL_BMOD  7
`define ASC_FL_RST  0
`define ASC_FL_ABT  1
`define ASC_FL_LOAD_OK_REQUEST 2
`define ASC_FL_TRIGGER_REQUEST 3
`define ASC_IRQ_EOC  0
`define ASC_IRQ_ABD  1
`define ASC_IRQ_EOL  2
`define ASC_IRQ_STOP 3
`define ASC_CTRL_RST 8'h00
`define ASC_WORD_RST 32'h0000_0000
`define ASC_IDX_RST  8'h00
`define ASC_CMD_RST  4'h0
`endif

// *** core/asc_pkg.sv ***
// types of the stop-flow and result-store block
package asc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_STOP = 4'b0100,
        ST_WAKE = 4'b1000
    } asc_state_t;
    typedef enum logic [1:0] {
        RES_8  = 2'h0,
        RES_10 = 2'h1,
        RES_12 = 2'h2
    } asc_res_t;
endpackage

// *** core/asc_justify.sv ***
// places a raw conversion result into the 16-bit result word
`timescale 1ns/1ps
module asc_justify (
    input  wire logic [11:0] raw,
    input  wire logic [1:0]  res_sel,
    input  wire logic        right_just,
    output logic      [15:0] word
);
    import asc_pkg::*;
    wire [15:0] left8   = {raw[7:0], 8'h00};
    wire [15:0] left10  = {raw[9:0], 6'h00};
    wire [15:0] left12  = {raw[11:0], 4'h0};
    wire [15:0] right8  = {8'h00, raw[7:0]};
    wire [15:0] right10 = {6'h00, raw[9:0]};
    wire [15:0] right12 = {4'h0, raw[11:0]};
    // unused positions are zero in every form; reserved code 3 acts as 12 bit
    wire [15:0] lsel = (res_sel == RES_8) ? left8 : (res_sel == RES_10) ? left10 : left12;
    wire [15:0] rsel = (res_sel == RES_8) ? right8 : (res_sel == RES_10) ? right10 : right12;
    assign word = right_just ? rsel : lsel;
endmodule

// *** core/asc_top.sv ***
// stop-mode flow control and result store of the converter, with AHB-Lite registers
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        stop_req,
    output logic             stop_ack,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic      [3:0]  command_index,
    input  wire logic        cmd_last,
    input  wire logic        cmd_loop,
    output logic             res_wr,
    output logic      [31:0] res_addr,
    output logic      [15:0] res_data,
    output logic             irq
);
    import asc_pkg::*;

    asc_state_t  state_ff, nxt_state;
    logic [7:0]  ctrl_ff;
    logic [3:0]  flow_ff, nxt_flow;
    logic [31:0] base_ff, offs_ff;
    logic [7:0]  ridx_ff, nxt_ridx;
    logic [3:0]  cmd_ff, nxt_cmd;
    logic        sel_ff, nxt_sel;
    logic        stop_abort_ff, nxt_stop_abort;
    logic [3:0]  istat_ff, ien_ff;
    logic [15:0] last_ff;
    logic        res_wr_ff, start_ff;
    logic [31:0] res_addr_ff;
    logic [15:0] res_data_ff;
    logic        a_valid_ff, a_write_ff;
    logic [7:0]  a_addr_ff;
    logic        start, store, clr_idx, set_abd, set_eol;
    logic [15:0] j_word;

    // control fields
    wire        en       = ctrl_ff[`ASC_CTRL_EN];
    wire        keep_abt = ctrl_ff[`ASC_CTRL_STORE];
    wire        rst_mode = ctrl_ff[`ASC_CTRL_FMODE];
    wire        auto_rs  = ctrl_ff[`ASC_CTRL_AUTO];
    wire        single   = ctrl_ff[`ASC_CTRL_BMOD];
    wire [1:0]  res_sel  = ctrl_ff[`ASC_CTRL_RESHI:`ASC_CTRL_RESLO];

    // bus decode: zero-wait slave, address captured in the address phase
    wire        a_take  = hsel && htrans[1] && hready;
    wire        wr      = a_valid_ff && a_write_ff;
    wire        wr_ctrl = wr && (a_addr_ff == `ASC_OFF_CTRL);
    wire        wr_flow = wr && (a_addr_ff == `ASC_OFF_FLOW);
    wire        wr_base = wr && (a_addr_ff == `ASC_OFF_BASE);
    wire        wr_offs = wr && (a_addr_ff == `ASC_OFF_OFFS);
    wire        wr_ridx = wr && (a_addr_ff == `ASC_OFF_RIDX);
    wire        wr_iclr = wr && (a_addr_ff == `ASC_OFF_ICLR);
    wire        wr_ien  = wr && (a_addr_ff == `ASC_OFF_IEN);
    wire        ptr_wen = !en;
    wire [3:0]  flow_set = (wr_flow && en) ? hwdata[3:0] : 4'h0;
    wire [31:0] stat_word = {8'h00, ridx_ff, 4'h0, cmd_ff, 3'h0, sel_ff, state_ff};
    wire [31:0] rd_mux =
        (a_addr_ff == `ASC_OFF_CTRL)  ? {24'h000000, ctrl_ff} :
        (a_addr_ff == `ASC_OFF_FLOW)  ? {28'h0000000, flow_ff} :
        (a_addr_ff == `ASC_OFF_STAT)  ? stat_word :
        (a_addr_ff == `ASC_OFF_BASE)  ? base_ff :
        (a_addr_ff == `ASC_OFF_OFFS)  ? offs_ff :
        (a_addr_ff == `ASC_OFF_RIDX)  ? {24'h000000, ridx_ff} :
        (a_addr_ff == `ASC_OFF_ISTAT) ? {28'h0000000, istat_ff} :
        (a_addr_ff == `ASC_OFF_IEN)   ? {28'h0000000, ien_ff} :
        (a_addr_ff == `ASC_OFF_RES)   ? {16'h0000, last_ff} : 32'h0000_0000;
    assign hrdata    = (a_valid_ff && !a_write_ff) ? rd_mux : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // result word placement
    asc_justify u_just (
        .raw        (conv_data),
        .res_sel    (res_sel),
        .right_just (ctrl_ff[`ASC_CTRL_JUST]),
        .word       (j_word)
    );

    // list offset of the active buffer; single-buffer mode pins list 0
    wire [31:0] list_off = sel_ff ? {16'h0000, offs_ff[31:16]} : {16'h0000, offs_ff[15:0]};
    wire [31:0] wr_addr  = base_ff + list_off + {23'h000000, ridx_ff, 1'b0};
    wire        conv_ok  = state_ff == ST_CONV && conv_done;
    wire        aborting = stop_abort_ff || flow_ff[`ASC_FL_ABT];

    // sequencer: idle, converting, stopped, one wake cycle
    always_comb begin
        nxt_state      = state_ff;
        nxt_flow       = flow_ff | flow_set;
        nxt_cmd        = cmd_ff;
        nxt_sel        = sel_ff;
        nxt_stop_abort = stop_abort_ff;
        start          = 1'b0;
        store          = 1'b0;
        clr_idx        = 1'b0;
        set_abd        = 1'b0;
        set_eol        = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (stop_req) begin
                    nxt_state = ST_STOP;
                end else if (!en) begin
                    nxt_state = ST_IDLE;
                end else if (flow_ff[`ASC_FL_ABT]) begin
                    // nothing running, so the abort is done at once
                    nxt_flow[`ASC_FL_ABT] = 1'b0;
                    set_abd = 1'b1;
                end else if (flow_ff[`ASC_FL_RST]) begin
                    // restart is taken before a pending trigger
                    nxt_flow[`ASC_FL_RST]  = 1'b0;
                    nxt_flow[`ASC_FL_LOAD_OK_REQUEST] = 1'b0;
                    clr_idx = 1'b1;
                    if (rst_mode) begin
                        start     = 1'b1;
                        nxt_state = ST_CONV;
                    end
                end else if (flow_ff[`ASC_FL_TRIGGER_REQUEST] && !rst_mode) begin
                    nxt_flow[`ASC_FL_TRIGGER_REQUEST] = 1'b0;
                    start     = 1'b1;
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (stop_req) begin
                    nxt_stop_abort = 1'b1;
                end
                if (conv_done && (aborting || stop_req)) begin
                    store = keep_abt;
                    nxt_flow[`ASC_FL_ABT] = 1'b0;
                    if (stop_abort_ff || stop_req) begin
                        nxt_state      = ST_STOP;
                        nxt_stop_abort = 1'b0;
                    end else begin
                        set_abd   = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end else if (conv_done) begin
                    store = 1'b1;
                    if (cmd_last) begin
                        set_eol = 1'b1;
                        nxt_cmd = `ASC_CMD_RST;
                        if (cmd_loop) begin
                            start = 1'b1;
                        end else begin
                            nxt_state = ST_IDLE;
                            nxt_sel   = single ? 1'b0 : !sel_ff;
                        end
                    end else begin
                        nxt_cmd = cmd_ff + 4'h1;
                        start   = 1'b1;
                    end
                end
            end
            ST_STOP: begin
                // the list select is left alone so the same buffer resumes
                if (!stop_req) begin
                    nxt_state = ST_WAKE;
                end
            end
            ST_WAKE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (clr_idx) begin
            nxt_cmd = `ASC_CMD_RST;
        end
        if (single) begin
            nxt_sel = 1'b0;
        end
        // requests cannot survive a stop; writes during stop are dropped too
        if (stop_req || state_ff == ST_STOP) begin
            nxt_flow = 4'h0;
        end
        // auto restart on wake raises restart, and trigger in trigger mode; a stop request raised again keeps everything cleared
        if (state_ff == ST_WAKE && auto_rs && !stop_req) begin
            nxt_flow[`ASC_FL_RST]  = 1'b1;
            nxt_flow[`ASC_FL_TRIGGER_REQUEST] = !rst_mode;
        end
    end

    // result index: hardware owns it while enabled
    always_comb begin
        nxt_ridx = ridx_ff;
        if (clr_idx) begin
            nxt_ridx = `ASC_IDX_RST;
        end else if (store) begin
            nxt_ridx = ridx_ff + 8'h01;
        end else if (wr_ridx && ptr_wen) begin
            nxt_ridx = hwdata[7:0];
        end
    end

    // events; a set in the clearing cycle wins
    wire [3:0] ev = {nxt_state == ST_STOP && state_ff != ST_STOP, set_eol, set_abd, store};
    wire [3:0] clr_mask = wr_iclr ? hwdata[3:0] : 4'h0;
    wire [3:0] nxt_istat = (istat_ff & ~clr_mask) | ev;

    // bus address phase
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_valid_ff <= 1'b0;
            a_write_ff <= 1'b0;
            a_addr_ff  <= 8'h00;
        end else if (ce) begin
            a_valid_ff <= a_take;
            a_write_ff <= hwrite;
            a_addr_ff  <= haddr[7:0];
        end
    end

    // software registers; pointers locked while enabled
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_ff <= `ASC_CTRL_RST;
            base_ff <= `ASC_WORD_RST;
            offs_ff <= `ASC_WORD_RST;
            ien_ff  <= 4'h0;
        end else if (ce) begin
            if (wr_ctrl) ctrl_ff <= hwdata[7:0];
            if (wr_base && ptr_wen) base_ff <= hwdata;
            if (wr_offs && ptr_wen) offs_ff <= hwdata;
            if (wr_ien) ien_ff <= hwdata[3:0];
        end
    end

    // sequencer state and indices
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff      <= ST_IDLE;
            flow_ff       <= 4'h0;
            cmd_ff        <= `ASC_CMD_RST;
            ridx_ff       <= `ASC_IDX_RST;
            sel_ff        <= 1'b0;
            stop_abort_ff <= 1'b0;
            istat_ff      <= 4'h0;
        end else if (ce) begin
            state_ff      <= nxt_state;
            flow_ff       <= nxt_flow;
            cmd_ff        <= nxt_cmd;
            ridx_ff       <= nxt_ridx;
            sel_ff        <= nxt_sel;
            stop_abort_ff <= nxt_stop_abort;
            istat_ff      <= nxt_istat;
        end
    end

    // result write port and conversion start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            res_wr_ff   <= 1'b0;
            res_addr_ff <= `ASC_WORD_RST;
            res_data_ff <= 16'h0000;
            last_ff     <= 16'h0000;
            start_ff    <= 1'b0;
        end else if (ce) begin
            res_wr_ff <= store;
            start_ff  <= start;
            if (store) begin
                res_addr_ff <= wr_addr;
                res_data_ff <= j_word;
                last_ff     <= j_word;
            end
        end
    end

    assign res_wr        = res_wr_ff;
    assign res_addr      = res_addr_ff;
    assign res_data      = res_data_ff;
    assign conv_start    = start_ff;
    assign command_index = cmd_ff;
    assign stop_ack      = state_ff == ST_STOP;
    assign irq           = |(istat_ff & ien_ff);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_flow_held: assert property (state_ff == ST_STOP |-> flow_ff == 4'h0)
        else $error("flow request set during stop");
    a_abort_wait: assert property (ce && state_ff == ST_CONV && stop_abort_ff && !conv_done |=> state_ff == ST_CONV)
        else $error("stop abort left before conversion finished");
    a_stop_noflag: assert property (ce && conv_ok && stop_abort_ff |=> state_ff == ST_STOP && !$rose(istat_ff[`ASC_IRQ_ABD]))
        else $error("stop abort set abort done or missed stop");
    a_abort_store: assert property (ce && conv_ok && stop_abort_ff |=> res_wr_ff == $past(keep_abt))
        else $error("abort store does not follow store bit");
    a_wake_trigger_request: assert property (ce && state_ff == ST_WAKE && auto_rs && !rst_mode && !stop_req
                                  |=> flow_ff[`ASC_FL_RST] && flow_ff[`ASC_FL_TRIGGER_REQUEST])
        else $error("trigger mode wake did not set restart and trigger");
    a_wake_rst: assert property (ce && state_ff == ST_WAKE && auto_rs && rst_mode && !stop_req
                                 |=> flow_ff[`ASC_FL_RST] && !flow_ff[`ASC_FL_ABT] && !flow_ff[`ASC_FL_TRIGGER_REQUEST])
        else $error("restart mode wake set wrong requests");
    a_restart_clr: assert property (ce && clr_idx |=> cmd_ff == 4'h0 && ridx_ff == 8'h00)
        else $error("restart did not clear indices");
    a_sel_stop: assert property (ce && state_ff == ST_CONV && nxt_state == ST_STOP |=> sel_ff == $past(sel_ff))
        else $error("list select changed at stop");
    a_ridx_ro: assert property (ce && wr_ridx && en && !store && !clr_idx |=> ridx_ff == $past(ridx_ff))
        else $error("index written while enabled");
    a_pad_zero: assert property (res_sel == RES_8 && ctrl_ff[`ASC_CTRL_JUST] |-> j_word[15:8] == 8'h00)
        else $error("unused high bits not zero");
    a_left_just: assert property (res_sel == RES_12 && !ctrl_ff[`ASC_CTRL_JUST]
                                  |-> j_word == {conv_data, 4'h0})
        else $error("left justification wrong");

    a_flow_clear: assert property (ce && stop_req |=> flow_ff == 4'h0)
        else $error("flow request survived a stop request");
    a_pad_left: assert property (res_sel == RES_10 && !ctrl_ff[`ASC_CTRL_JUST]
                                 |-> j_word[5:0] == 6'h00)
        else $error("unused low bits not zero");

    c_stop_run: cover property (state_ff == ST_CONV && stop_req ##[1:50] state_ff == ST_STOP);
    c_wake_auto: cover property (state_ff == ST_WAKE && auto_rs ##[1:10] state_ff == ST_CONV);
    c_list_end: cover property (set_eol && !cmd_loop);
    c_sw_abort: cover property (conv_ok && flow_ff[`ASC_FL_ABT] && !stop_req);
endmodule

// *** bench/asc_top_test.sv ***
// self-checking bench for the stop-flow and result-store block
`timescale 1ns/1ps
`include "asc_defs.svh"
module asc_top_test;
    import asc_pkg::*;
    typedef struct {
        logic [7:0]  ctrl;
        logic [11:0] raw;
        logic [15:0] res;
    } asc_row_t;
    logic        ref_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        stop_req;
    logic        stop_ack;
    logic        conv_start;
    logic        conv_done;
    logic [11:0] conv_data;
    logic [3:0]  command_index;
    logic        cmd_last;
    logic        cmd_loop;
    logic        res_wr;
    logic [31:0] res_addr;
    logic [15:0] res_data;
    logic        irq;
    logic [31:0] rd;
    logic [31:0] w_addr;
    logic [15:0] w_data;
    logic        seen;
    int          miscompares;
    int          n_tests;
    asc_row_t    rows [6];

    asc_top uut (
        .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req), .stop_ack(stop_ack),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .command_index(command_index), .cmd_last(cmd_last), .cmd_loop(cmd_loop),
        .res_wr(res_wr), .res_addr(res_addr), .res_data(res_data), .irq(irq)
    );
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // 25 MHz bus clock
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one single-word transfer; the master never assumes a latency
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // bounded wait at the falling edge, where outputs have settled
    task automatic wait_hi(input int sel);
        int i;
        i = 0;
        while (((sel == 0) ? conv_start : stop_ack) !== 1'b1 && i < 40) begin
            @(negedge ref_clk);
            i++;
        end
        chk(sel == 0 ? "conv_start" : "stop_ack", {31'h0, (sel == 0) ? conv_start : stop_ack}, 32'h1);
    endtask

    // converter side: one-cycle done pulse, data replaced afterwards
    task automatic pulse_done(input logic [11:0] raw, input logic last);
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_data <= raw;
        cmd_last <= last;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        conv_data <= ~raw;
    endtask

    task automatic wait_wr;
        seen = 1'b0;
        repeat (4) begin
            @(negedge ref_clk);
            if (res_wr === 1'b1) begin
                seen = 1'b1;
                w_data = res_data;
                w_addr = res_addr;
            end
        end
    endtask

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrap_up;
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        stop_req = 1'b0;
        conv_done = 1'b0;
        conv_data = 12'h000;
        cmd_last = 1'b0;
        cmd_loop = 1'b0;
        miscompares = 0;
        n_tests = 0;
        // single buffer mode so every result lands in list 0
        rows[0] = '{8'h81, 12'hABC, 16'hBC00};
        rows[1] = '{8'h91, 12'hABC, 16'h00BC};
        rows[2] = '{8'hA1, 12'hABC, 16'hAF00};
        rows[3] = '{8'hB1, 12'hABC, 16'h02BC};
        rows[4] = '{8'hC1, 12'hABC, 16'hABC0};
        rows[5] = '{8'hD1, 12'hABC, 16'h0ABC};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        bus(`ASC_OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        bus(`ASC_OFF_STAT, 1'b0, 32'h0);
        chk("stat reset", rd, 32'h1);
        chk("hresp okay", {31'h0, hresp}, 32'h0);
        bus(`ASC_OFF_BASE, 1'b1, 32'h1000);
        bus(`ASC_OFF_OFFS, 1'b1, 32'h0020_0010);
        // justification table, restart plus trigger before each result
        foreach (rows[k]) begin
            bus(`ASC_OFF_CTRL, 1'b1, {24'h0, rows[k].ctrl});
            bus(`ASC_OFF_FLOW, 1'b1, 32'h9);
            wait_hi(0);
            pulse_done(rows[k].raw, 1'b1);
            wait_wr;
            chk("res_wr", {31'h0, seen}, 32'h1);
            chk("res_data", {16'h0, w_data}, {16'h0, rows[k].res});
            chk("res_addr", w_addr, 32'h1010);
            bus(`ASC_OFF_RES, 1'b0, 32'h0);
            chk("res reg", rd, {16'h0, rows[k].res});
        end
        // pointer registers are locked while enabled; one result since restart
        bus(`ASC_OFF_BASE, 1'b1, 32'h2000);
        bus(`ASC_OFF_RIDX, 1'b1, 32'h7);
        bus(`ASC_OFF_BASE, 1'b0, 32'h0);
        chk("base locked", rd, 32'h1000);
        bus(`ASC_OFF_RIDX, 1'b0, 32'h0);
        chk("index owned", rd, 32'h1);
        bus(`ASC_OFF_STAT, 1'b0, 32'h0);
        chk("select", {31'h0, rd[4]}, 32'h0);
        bus(8'h40, 1'b0, 32'h0);
        chk("unmapped", rd, 32'h0);
        // interrupt: masked, enabled, cleared
        bus(`ASC_OFF_IEN, 1'b1, 32'h0);
        @(negedge ref_clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        bus(`ASC_OFF_IEN, 1'b1, 32'h1);
        @(negedge ref_clk);
        chk("irq set", {31'h0, irq}, 32'h1);
        bus(`ASC_OFF_ICLR, 1'b1, 32'hF);
        @(negedge ref_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        // software abort in idle reports abort done
        bus(`ASC_OFF_FLOW, 1'b1, 32'h2);
        bus(`ASC_OFF_ISTAT, 1'b0, 32'h0);
        chk("sw abort done", {31'h0, rd[1]}, 32'h1);
        bus(`ASC_OFF_ICLR, 1'b1, 32'hF);
        // stop in mid-run, both flow modes, with and without store on abort
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 2; s++) begin
                // double buffer: the select flips after each finished list
                bus(`ASC_OFF_CTRL, 1'b1, 32'h09 | (s << 1) | (m << 2));
                bus(`ASC_OFF_FLOW, 1'b1, m ? 32'h1 : 32'h9);
                wait_hi(0);
                // one finished command first, so both indices are non-zero at the stop
                pulse_done(12'h111, 1'b0);
                @(posedge ref_clk);
                stop_req <= 1'b1;
                pulse_done(12'h5A5, 1'b0);
                wait_wr;
                chk("abort store", {31'h0, seen}, s);
                if (s) begin
                    chk("abort data", {16'h0, w_data}, 32'hA500);
                    chk("abort addr", w_addr, 32'h1022);
                end
                wait_hi(1);
                bus(`ASC_OFF_FLOW, 1'b1, 32'hF);
                bus(`ASC_OFF_FLOW, 1'b0, 32'h0);
                chk("flow in stop", rd, 32'h0);
                bus(`ASC_OFF_ISTAT, 1'b0, 32'h0);
                chk("stop flags", {28'h0, rd[3:0] & 4'hA}, 32'h8);
                bus(`ASC_OFF_STAT, 1'b0, 32'h0);
                chk("stop select", {31'h0, rd[4]}, s);
                bus(`ASC_OFF_ICLR, 1'b1, 32'hF);
                @(posedge ref_clk);
                stop_req <= 1'b0;
                wait_hi(0);
                chk("wake command_index", {28'h0, command_index}, 32'h0);
                pulse_done(12'h3C3, 1'b1);
                wait_wr;
                chk("wake addr", w_addr, s ? 32'h1020 : 32'h1010);
            end
        end
        // continuous two-command list, ended by a software abort in mid-run
        @(posedge ref_clk);
        cmd_loop <= 1'b1;
        bus(`ASC_OFF_ICLR, 1'b1, 32'hF);
        bus(`ASC_OFF_CTRL, 1'b1, 32'h81);
        bus(`ASC_OFF_FLOW, 1'b1, 32'h9);
        wait_hi(0);
        pulse_done(12'h111, 1'b0);
        wait_hi(0);
        chk("multi command_index", {28'h0, command_index}, 32'h1);
        pulse_done(12'h222, 1'b1);
        wait_hi(0);
        chk("loop command_index", {28'h0, command_index}, 32'h0);
        bus(`ASC_OFF_FLOW, 1'b1, 32'h2);
        pulse_done(12'h333, 1'b1);
        bus(`ASC_OFF_ISTAT, 1'b0, 32'h0);
        chk("run abort flags", {28'h0, rd[3:0] & 4'hA}, 32'h2);
        // stop only from idle once abort done is seen; auto restart is off here
        bus(`ASC_OFF_ICLR, 1'b1, 32'hF);
        @(posedge ref_clk);
        stop_req <= 1'b1;
        wait_hi(1);
        bus(`ASC_OFF_ISTAT, 1'b0, 32'h0);
        chk("idle stop flags", {28'h0, rd[3:0] & 4'hA}, 32'h8);
        @(posedge ref_clk);
        stop_req <= 1'b0;
        bus(`ASC_OFF_FLOW, 1'b0, 32'h0);
        chk("no auto wake", rd, 32'h0);
        wrap_up;
    end
endmodule
